// File: logic/i2csrp_pkg.sv
// Constants, states and carrier types of the two-wire slave register port
package i2csrp_pkg;

   // Serial frame layout
   localparam int unsigned BYTE_BITS = 8;
   localparam logic [3:0] LAST_BIT_CNT = 4'h7;
   localparam logic [3:0] ACK_SLOT_CNT = 4'h8;
   localparam logic [3:0] FIRST_BIT_CNT = 4'h0;

   // Device write address base; select pins fill bits 2:1, read address sets bit 0
   localparam logic [7:0] WR_ADDR_BASE = 8'h80;
   localparam int unsigned SEL_LSB = 1;
   localparam int unsigned SEL_WIDTH = 2;

   // Sub-address pointer: bit 7 selects the auto-increment alias
   localparam int unsigned PTR_WIDTH = 8;
   localparam int unsigned IDX_WIDTH = 7;
   localparam int unsigned AUTO_INC_BIT = 7;
   localparam int unsigned REG_DEPTH = 128;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [6:0] IDX_STEP = 7'h01;

   // Reference clock and clock-stretch hold
   localparam int unsigned REF_CLK_HZ = 20_000_000;
   localparam int unsigned STRETCH_NS = 200;
   localparam int unsigned STRETCH_CYC_RAW =
      (STRETCH_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned STRETCH_CYC = (STRETCH_CYC_RAW < 1) ? 1 : STRETCH_CYC_RAW;
   localparam int unsigned STRETCH_W = 4;
   localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(STRETCH_CYC);
   localparam logic [STRETCH_W-1:0] STRETCH_ZERO = 4'h0;

   // Falling edges between a byte event and the end of its acknowledge clock
   localparam logic [1:0] ARM_FALLS = 2'h2;
   localparam logic [1:0] ARM_LAST = 2'h1;
   localparam logic [1:0] ARM_IDLE = 2'h0;

   // Link-side byte state, Gray sequence address -> write -> read -> ignore
   typedef enum logic [1:0] {
      LS_ADDR = 2'b00,
      LS_WR = 2'b01,
      LS_RD = 2'b11,
      LS_IGN = 2'b10
   } i2csrp_link_st_e;

   // Bus condition tracker on the reference clock
   typedef enum logic [1:0] {
      BS_IDLE = 2'b00,
      BS_START = 2'b01,
      BS_ACTIVE = 2'b11
   } i2csrp_bus_st_e;

   typedef enum logic [1:0] {
      EV_ADDR_WR = 2'b00,
      EV_ADDR_RD = 2'b01,
      EV_DATA_WR = 2'b11,
      EV_DATA_RD = 2'b10
   } i2csrp_ev_kind_e;

   // Byte event handed from the link domain to the reference domain
   typedef struct packed {
      i2csrp_ev_kind_e kind;
      logic [7:0] data;
   } i2csrp_ev_s;

endpackage

// File: logic/i2csrp_sync.sv
// Two-flop level synchroniser, one stage pair per bit
`timescale 1ns/10ps
module i2csrp_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // Pins idle high, so a high reset keeps edge detectors from seeing a false fall
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '1;
         sync_r <= '1;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;

endmodule

// File: logic/i2csrp_regstore.sv
// Control register store: one write port, a port-side and a core-side read port
`timescale 1ns/10ps
module i2csrp_regstore
   import i2csrp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [IDX_WIDTH-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic [IDX_WIDTH-1:0] i_raddr,
   output logic [7:0] o_rdata,
   input wire logic [IDX_WIDTH-1:0] i_core_addr,
   output logic [7:0] o_core_data
);

   logic [7:0] mem [REG_DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   assign o_rdata = mem[i_raddr];
   assign o_core_data = mem[i_core_addr];

endmodule

// File: logic/i2csrp_port.sv
// Two-wire slave register port: link logic on the serial clock, store on the reference clock
//
// Behaviour
// - Write address 80h/82h/84h/86h chosen by select pins; read address adds one.
// - Watch all traffic; touch registers only when own address is received.
// - First byte after start: seven address bits then direction, high means read.
// - Transfers are 8-bit bytes, each followed by one acknowledge slot.
// - Transmitter releases data in ack slot; addressed receiver holds it low.
// - Device may hold the clock low after an acknowledge until ready.
// - Data falling while clock high is a start; bus busy from then.
// - Data rising while clock high is a stop ending the transaction.
// - Data changes only while clock is low, except start and stop.
// - First written byte after the address loads the sub-address pointer.
// - Later written bytes go to the register the pointer selects, acknowledged.
// - Master may send more data bytes, each acknowledged, until a stop.
// - A read starts at the most recently written sub-address.
// - In a read device drives bytes, releases at ninth clock; master acknowledges.
// - Sub-addresses 80h-FFh alias 00h-7Fh with bit 7 ignored.
// - In the 80h-FFh range each byte written or read advances the pointer.
`timescale 1ns/10ps
module i2csrp_port
   import i2csrp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_scl_clk,
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe_n,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input wire logic [SEL_WIDTH-1:0] i_slave_address_select_pins,
   input wire logic [IDX_WIDTH-1:0] i_core_addr,
   output logic [7:0] o_core_data,
   output logic o_bus_busy,
   output logic [PTR_WIDTH-1:0] o_sub_addr
);

   // ---------------------------------------------------------------
   // Reference-domain declarations
   // ---------------------------------------------------------------
   logic [SEL_WIDTH+2:0] sync_in;
   logic [SEL_WIDTH+2:0] sync_out;
   logic ev_s;
   logic scl_s;
   logic sda_s;
   logic [SEL_WIDTH-1:0] sel_s;
   logic scl_d_r;
   logic sda_d_r;
   i2csrp_bus_st_e bus_st_r;
   i2csrp_bus_st_e bus_st_nxt;
   logic link_hold_r;
   logic [7:0] own_addr_r;
   logic ev_seen_r;
   logic sub_pend_r;
   logic [PTR_WIDTH-1:0] ptr_r;
   logic [PTR_WIDTH-1:0] ptr_nxt;
   logic [7:0] tx_byte_r;
   logic [7:0] core_data_r;
   logic [1:0] arm_r;
   logic [STRETCH_W-1:0] stretch_r;
   logic scl_oe_n_r;
   logic [7:0] store_rdata;
   logic [7:0] store_core;

   // ---------------------------------------------------------------
   // Link-domain declarations
   // ---------------------------------------------------------------
   logic link_rst;
   i2csrp_link_st_e lst_r;
   logic [3:0] cnt_r;
   logic [7:0] shift_r;
   logic match_r;
   logic rw_r;
   logic ev_tgl_r;
   i2csrp_ev_s ev_r;
   logic [7:0] tx_r;
   logic sda_oe_n_r;

   // Link-domain decode
   logic [7:0] rx_next;
   logic last_bit;
   logic ack_slot;
   logic addr_hit;
   logic ack_drive;

   // Reference-domain decode
   logic start_cond;
   logic stop_cond;
   logic scl_fall;
   logic ev_new;
   i2csrp_ev_kind_e ev_kind;
   logic is_sub_load;
   logic is_data_wr;
   logic is_data_rd;
   logic store_we;
   logic [PTR_WIDTH-1:0] ptr_step;

   // ===============================================================
   // Link domain: runs on the serial clock pin, frozen outside frames
   // ===============================================================

   // Held in reset between frames and from a start until the clock first goes low,
   // so the bit counter always begins at the first address bit
   assign link_rst = i_rst | link_hold_r;

   // Data is launched by the far end on the low phase, so sampling on the
   // rising clock edge sees a settled level without further synchronising
   assign rx_next = {shift_r[6:0], i_sda};
   assign last_bit = (cnt_r == LAST_BIT_CNT);
   assign ack_slot = (cnt_r == ACK_SLOT_CNT);
   // Only the seven address bits are compared; bit 0 is the direction
   assign addr_hit = (rx_next[7:1] == own_addr_r[7:1]);

   always_ff @(posedge i_scl_clk or posedge link_rst) begin
      if (link_rst) begin
         lst_r <= LS_ADDR;
         cnt_r <= FIRST_BIT_CNT;
         shift_r <= 8'h00;
         match_r <= 1'b0;
         rw_r <= 1'b0;
         ev_tgl_r <= 1'b0;
         ev_r <= '0;
      end else if (ack_slot) begin
         cnt_r <= FIRST_BIT_CNT;
         case (lst_r)
            LS_ADDR: begin
               if (!match_r) begin
                  lst_r <= LS_IGN;
               end else if (rw_r) begin
                  lst_r <= LS_RD;
               end else begin
                  lst_r <= LS_WR;
               end
            end
            LS_RD: begin
               // Released data in the ack slot means the master declined more
               if (i_sda) begin
                  lst_r <= LS_IGN;
               end
            end
            LS_WR: lst_r <= LS_WR;
            LS_IGN: lst_r <= LS_IGN;
            default: lst_r <= LS_IGN;
         endcase
      end else begin
         shift_r <= rx_next;
         cnt_r <= cnt_r + 4'h1;
         if (last_bit) begin
            case (lst_r)
               LS_ADDR: begin
                  match_r <= addr_hit;
                  rw_r <= rx_next[0];
                  if (addr_hit) begin
                     ev_r.kind <= rx_next[0] ? EV_ADDR_RD : EV_ADDR_WR;
                     ev_r.data <= rx_next;
                     ev_tgl_r <= ~ev_tgl_r;
                  end
               end
               LS_WR: begin
                  ev_r.kind <= EV_DATA_WR;
                  ev_r.data <= rx_next;
                  ev_tgl_r <= ~ev_tgl_r;
               end
               LS_RD: begin
                  ev_r.kind <= EV_DATA_RD;
                  ev_r.data <= rx_next;
                  ev_tgl_r <= ~ev_tgl_r;
               end
               LS_IGN: ev_r <= ev_r;
               default: ev_r <= ev_r;
            endcase
         end
      end
   end

   // Acknowledge low after a matching address and after every written byte
   assign ack_drive = ((lst_r == LS_ADDR) && match_r) || (lst_r == LS_WR);

   // Drive on the falling edge so data only moves while the clock is low
   always_ff @(negedge i_scl_clk or posedge link_rst) begin
      if (link_rst) begin
         sda_oe_n_r <= 1'b1;
         tx_r <= 8'h00;
      end else if (ack_slot) begin
         sda_oe_n_r <= ~ack_drive;
      end else if (lst_r == LS_RD) begin
         if (cnt_r == FIRST_BIT_CNT) begin
            // Read byte was settled by the reference side microseconds earlier
            tx_r <= {tx_byte_r[6:0], 1'b0};
            sda_oe_n_r <= tx_byte_r[7];
         end else begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_n_r <= tx_r[7];
         end
      end else begin
         sda_oe_n_r <= 1'b1;
      end
   end

   // ===============================================================
   // Reference domain: bus conditions, pointer, store and stretching
   // ===============================================================

   assign sync_in = {ev_tgl_r, i_scl, i_sda, i_slave_address_select_pins};

   i2csrp_sync #(
      .WIDTH(SEL_WIDTH + 3)
   ) u_sync (
      .i_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_async(sync_in),
      .o_sync(sync_out)
   );

   assign ev_s = sync_out[SEL_WIDTH+2];
   assign scl_s = sync_out[SEL_WIDTH+1];
   assign sda_s = sync_out[SEL_WIDTH];
   assign sel_s = sync_out[SEL_WIDTH-1:0];

   assign start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_cond = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign scl_fall = scl_d_r && !scl_s;

   always_comb begin
      bus_st_nxt = bus_st_r;
      if (start_cond) begin
         bus_st_nxt = BS_START;
      end else if (stop_cond) begin
         bus_st_nxt = BS_IDLE;
      end else begin
         case (bus_st_r)
            BS_IDLE: bus_st_nxt = BS_IDLE;
            BS_START: bus_st_nxt = scl_s ? BS_START : BS_ACTIVE;
            BS_ACTIVE: bus_st_nxt = BS_ACTIVE;
            default: bus_st_nxt = BS_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         bus_st_r <= BS_IDLE;
         link_hold_r <= 1'b1;
         own_addr_r <= WR_ADDR_BASE;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         bus_st_r <= bus_st_nxt;
         // Release only while the clock is low, well clear of its next rise
         link_hold_r <= (bus_st_nxt != BS_ACTIVE);
         own_addr_r <= WR_ADDR_BASE | 8'({sel_s, 1'b0});
      end
   end

   // Byte events from the link; the word in ev_r stands still until the next byte
   assign ev_new = (ev_s != ev_seen_r) && (bus_st_r == BS_ACTIVE);
   assign ev_kind = ev_r.kind;
   assign is_sub_load = ev_new && (ev_kind == EV_DATA_WR) && sub_pend_r;
   assign is_data_wr = ev_new && (ev_kind == EV_DATA_WR) && !sub_pend_r;
   assign is_data_rd = ev_new && (ev_kind == EV_DATA_RD);
   assign store_we = is_data_wr;

   // Upper alias steps within itself; lower range holds still
   assign ptr_step = ptr_r[AUTO_INC_BIT] ?
      {1'b1, ptr_r[IDX_WIDTH-1:0] + IDX_STEP} : ptr_r;

   always_comb begin
      ptr_nxt = ptr_r;
      if (is_sub_load) begin
         ptr_nxt = ev_r.data;
      end else if (is_data_wr || is_data_rd) begin
         ptr_nxt = ptr_step;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ev_seen_r <= 1'b0;
         sub_pend_r <= 1'b0;
         ptr_r <= PTR_RESET;
         tx_byte_r <= 8'h00;
         core_data_r <= 8'h00;
      end else begin
         // While the link is held its toggle falls back to zero; absorb that
         if (link_hold_r || ev_new) begin
            ev_seen_r <= ev_s;
         end
         if (ev_new && (ev_kind == EV_ADDR_WR)) begin
            sub_pend_r <= 1'b1;
         end else if (is_sub_load || (ev_new && (ev_kind == EV_ADDR_RD))) begin
            sub_pend_r <= 1'b0;
         end
         ptr_r <= ptr_nxt;
         // Next read byte follows the live pointer, so reads resume where writing left it
         tx_byte_r <= store_rdata;
         core_data_r <= store_core;
      end
   end

   i2csrp_regstore u_store (
      .i_clk(i_ref_clk),
      .i_we(store_we),
      .i_waddr(ptr_r[IDX_WIDTH-1:0]),
      .i_wdata(ev_r.data),
      .i_raddr(ptr_r[IDX_WIDTH-1:0]),
      .o_rdata(store_rdata),
      .i_core_addr(i_core_addr),
      .o_core_data(store_core)
   );

   // Clock stretch: a byte event arms a hold that starts at the falling edge
   // closing its acknowledge clock, giving the store time to settle
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         arm_r <= ARM_IDLE;
         stretch_r <= STRETCH_ZERO;
         scl_oe_n_r <= 1'b1;
      end else if (link_hold_r) begin
         arm_r <= ARM_IDLE;
         stretch_r <= STRETCH_ZERO;
         scl_oe_n_r <= 1'b1;
      end else if (ev_new) begin
         arm_r <= ARM_FALLS;
      end else if (scl_fall && (arm_r == ARM_LAST)) begin
         arm_r <= ARM_IDLE;
         stretch_r <= STRETCH_LOAD;
         scl_oe_n_r <= 1'b0;
      end else begin
         if (scl_fall && (arm_r != ARM_IDLE)) begin
            arm_r <= arm_r - ARM_LAST;
         end
         if (stretch_r != STRETCH_ZERO) begin
            stretch_r <= stretch_r - STRETCH_W'(1);
         end
         scl_oe_n_r <= (stretch_r <= STRETCH_W'(1));
      end
   end

   // Open-drain pins: only ever pull low
   assign o_scl = 1'b0;
   assign o_sda = 1'b0;
   assign o_scl_oe_n = scl_oe_n_r;
   assign o_sda_oe_n = sda_oe_n_r;
   assign o_core_data = core_data_r;
   assign o_bus_busy = (bus_st_r != BS_IDLE);
   assign o_sub_addr = ptr_r;

endmodule

// File: sim/i2csrp_port_asserts.sv
// Concurrent checks on the pins of the two-wire slave register port
`timescale 1ns/10ps
module i2csrp_port_asserts
   import i2csrp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_scl,
   input wire logic o_sda,
   input wire logic o_scl_oe_n,
   input wire logic o_sda_oe_n,
   input wire logic o_bus_busy,
   input wire logic [PTR_WIDTH-1:0] o_sub_addr
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   a_busy_on_start: assert property ($fell(i_sda) && i_scl |-> ##[1:6] o_bus_busy)
      else $error("bus not busy after a start");
   a_stop_frees_bus: assert property ($rose(i_sda) && i_scl |-> ##[1:6] !o_bus_busy)
      else $error("bus still busy after a stop");
   // Stretch is a fixed four reference cycles
   a_stretch_len: assert property ($fell(o_scl_oe_n) |-> !o_scl_oe_n [*4] ##1 o_scl_oe_n)
      else $error("clock stretch length wrong");
   // Pulling a high clock would cut the master's high phase short
   a_stretch_clk_low: assert property ($fell(o_scl_oe_n) |-> !$past(i_scl))
      else $error("clock stretch began while the clock was high");
   a_sda_still_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
      else $error("data enable moved while the clock was high");
   a_sda_idle_free: assert property (!o_bus_busy |-> o_sda_oe_n)
      else $error("data pulled while the bus is idle");
   a_ptr_idle_hold: assert property (!o_bus_busy && !$past(o_bus_busy) |-> $stable(o_sub_addr))
      else $error("pointer moved while the bus is idle");
   a_open_drain_low: assert property (o_scl == 1'b0 && o_sda == 1'b0)
      else $error("open drain output value not low");
endmodule

// File: sim/i2csrp_master.sv
// Two-wire bus master model driving the port's pins
`timescale 1ns/10ps
module i2csrp_master (
   input wire logic i_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_low,
   output logic o_sda_low
);
   // Phases in reference cycles; a bit lasts 3 + lo + hi, kept above 50 for 400 kHz
   int lo = 23;
   int hi = 25;
   int stalls = 0;
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Release the clock and wait while the slave still holds it low
   task automatic rise();
      int k;
      k = 0;
      o_scl_low = 1'b0;
      w(1);
      while (!i_scl && k < 100) begin
         k++;
         stalls++;
         w(1);
      end
   endtask
   task automatic bitx(input logic b, output logic r);
      o_sda_low = !b;
      w(lo);
      rise();
      w(hi / 2);
      r = i_sda;
      w(hi - hi / 2);
      o_scl_low = 1'b1;
      w(2);
   endtask
   task automatic start();
      o_sda_low = 1'b0;
      w(lo);
      rise();
      w(hi / 2);
      o_sda_low = 1'b1;
      w(hi / 2);
      o_scl_low = 1'b1;
      w(2);
   endtask
   task automatic stop();
      o_sda_low = 1'b1;
      w(lo);
      rise();
      w(hi / 2);
      o_sda_low = 1'b0;
      w(hi);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(last, r);
   endtask
endmodule

// File: sim/test_i2c_slave_register_port.sv
// Self-checking bench for the two-wire slave register port
`timescale 1ns/10ps
module test_i2c_slave_register_port;
   import i2csrp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] sel;
   logic [6:0] core_addr;
   logic scl_val, sda_val, scl_oe_n, sda_oe_n, busy;
   logic [7:0] core_data, sub, ptr;
   logic [7:0] mem [128];
   logic [31:0] lfsr = 32'h251d_2045;
   wire m_scl_low, m_sda_low;
   // Open-drain wires with pull-ups
   wire scl = !(m_scl_low || !scl_oe_n);
   wire sda = !(m_sda_low || !sda_oe_n);
   int fails = 0;
   int total_checks = 0;

   i2csrp_port DUT (.i_ref_clk(clk), .i_rst(rst), .i_scl_clk(scl), .i_scl(scl),
      .o_scl(scl_val), .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(sda_val),
      .o_sda_oe_n(sda_oe_n), .i_slave_address_select_pins(sel), .i_core_addr(core_addr),
      .o_core_data(core_data), .o_bus_busy(busy), .o_sub_addr(sub));
   i2csrp_master m (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_low(m_scl_low),
      .o_sda_low(m_sda_low));

   always #25 clk = ~clk;

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   function automatic logic [7:0] own_addr(input logic [1:0] s);
      return 8'h80 | {5'h00, s, 1'b0};
   endfunction
   function automatic logic [7:0] step(input logic [7:0] p);
      return p[7] ? {1'b1, p[6:0] + 7'h01} : p;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] s, input int n);
      logic ack, hit;
      logic [7:0] d;
      hit = (a == own_addr(sel));
      m.start();
      m.wbyte(a, ack);
      chk(8'(ack), 8'(hit));
      m.wbyte(s, ack);
      chk(8'(ack), 8'(hit));
      if (hit) ptr = s;
      for (int i = 0; i < n; i++) begin
         d = rnd();
         m.wbyte(d, ack);
         chk(8'(ack), 8'(hit));
         if (hit) begin
            mem[ptr[6:0]] = d;
            ptr = step(ptr);
         end
      end
      m.stop();
      chk(sub, ptr);
      chk(8'(busy), 8'h00);
   endtask
   task automatic rd(input logic [7:0] s, input int n);
      logic ack;
      logic [7:0] d;
      m.start();
      m.wbyte(own_addr(sel), ack);
      m.wbyte(s, ack);
      ptr = s;
      m.start();
      m.wbyte(own_addr(sel) | 8'h01, ack);
      chk(8'(ack), 8'h01);
      for (int i = 0; i < n; i++) begin
         m.rbyte(i == n - 1, d);
         chk(d, mem[ptr[6:0]]);
         ptr = step(ptr);
      end
      m.stop();
      chk(sub, ptr);
   endtask
   task automatic core_chk(input logic [6:0] a);
      core_addr = a;
      repeat (2) @(posedge clk);
      #1;
      chk(core_data, mem[a]);
   endtask

   // About 53k cycles are expected; the limit leaves ample margin
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      $display("watchdog expired");
      conclude();
   end

   initial begin
      logic [7:0] s;
      sel = 2'b00;
      core_addr = 7'h00;
      ptr = PTR_RESET;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(sub, 8'h00);
      for (int t = 0; t < 4; t++) begin
         sel = 2'(t);
         for (int k = 0; k < 4; k++) wr(8'h80 | 8'(k << 1), 8'h05 + 8'(k), (k == t) ? 0 : 1);
      end
      repeat (4) wr(rnd() & 8'hfe, 8'h41, 1);
      $display("address test done");
      s = rnd();
      sel = s[1:0];
      repeat (3) begin
         s = rnd() & 8'h7f;
         wr(own_addr(sel), s, 3);
         core_chk(s[6:0]);
         rd(s, 2);
      end
      $display("fixed pointer test done");
      wr(own_addr(sel), 8'hfe, 4);
      rd(8'hfe, 4);
      core_chk(7'h00);
      $display("auto increment test done");
      // A two-cycle low phase releases the clock while the stretch still holds it
      m.lo = 2;
      m.hi = 46;
      m.stalls = 0;
      wr(own_addr(sel), 8'h90, 2);
      rd(8'h90, 2);
      chk(8'(m.stalls > 0), 8'h01);
      m.lo = 23;
      m.hi = 25;
      $display("clock stretch test done");
      conclude();
   end
endmodule

bind i2csrp_port i2csrp_port_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_scl(i_scl), .i_sda(i_sda), .o_scl(o_scl), .o_sda(o_sda), .o_scl_oe_n(o_scl_oe_n),
   .o_sda_oe_n(o_sda_oe_n), .o_bus_busy(o_bus_busy), .o_sub_addr(o_sub_addr));
